/* File: core/eipr_pkg.sv */
/*
  Package for the extended interrupt enable and priority register block.
  Assumes an 8-bit special-function-register access port from the core,
  one clock and a synchronous active-high reset.
*/
package eipr_pkg;

  // ---------------------------------------------------------------
  // Register addresses and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_PRIO_HIGH_ONE = 8'h85;
  localparam logic [7:0] ADDR_ENABLE_TWO    = 8'hAF;
  localparam logic [7:0] ADDR_PRIO_LOW_ONE  = 8'hF6;
  localparam logic [7:0] RESET_VALUE        = 8'h00;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int BIT_TIMER_THREE  = 7;
  localparam int BIT_COMPARATOR   = 5;
  localparam int BIT_COUNTER_ARR  = 4;
  localparam int BIT_CONV_DONE    = 3;
  localparam int BIT_CONV_WINDOW  = 2;
  localparam int BIT_PORT_MATCH   = 1;
  localparam int BIT_SERIAL_A     = 0;
  localparam int BIT_TEMP_EN      = 3;
  localparam int BIT_TIMER5_EN    = 2;
  localparam int BIT_TIMER4_EN    = 1;
  localparam int BIT_SERIAL_B_EN  = 0;
  localparam logic [7:0] ENABLE_TWO_MASK = 8'h0F;

  // Number of competing sources in the winner search.
  localparam int NUM_SOURCES = 7;

  function automatic logic [1:0] eipr_level(input logic hi, input logic lo);
    return {hi, lo};
  endfunction

endpackage

/* File: core/eipr_arbiter.sv */
/*
  Picks the highest-level pending request among the priority sources.
  Assumes requests and levels come from the same clock domain.
*/
`timescale 1ns/1ps
module eipr_arbiter
  import eipr_pkg::*;
#(
  parameter int N = NUM_SOURCES
) (
  input  wire logic           sys_clk,
  input  wire logic           rst,
  input  wire logic [N-1:0]   req,
  input  wire logic [2*N-1:0] levels,
  output logic                win_valid,
  output logic [2:0]          win_index,
  output logic [1:0]          win_level
);
  // The winner index is three bits wide, so at most eight sources fit.
  if (N < 1 || N > 8) begin : g_bad_width
    $error("eipr_arbiter: N must be 1 to 8");
  end

  logic       next_valid;
  logic [2:0] next_index;
  logic [1:0] next_level;

  // ---------------------------------------------------------------
  // Winner search: higher level wins, lower index breaks ties
  // ---------------------------------------------------------------
  always_comb begin
    next_valid = 1'b0;
    next_index = 3'h0;
    next_level = 2'h0;
    for (int i = 0; i < N; i++) begin
      if (req[i] && (!next_valid || levels[2*i +: 2] > next_level)) begin
        next_valid = 1'b1;
        next_index = 3'(i);
        next_level = levels[2*i +: 2];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      win_valid <= 1'b0;
      win_index <= 3'h0;
      win_level <= 2'h0;
    end else begin
      win_valid <= next_valid;
      win_index <= next_index;
      win_level <= next_level;
    end
  end

  a_winner_valid: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(|req) |=> win_valid)
    else $error("Arbiter missed a pending request.");

endmodule // eipr_arbiter

/* File: core/eipr_regs.sv */
/*
  Extended enable register two and extended priority register pair one.
  Assumes the core drives an 8-bit special-function-register port on
  sys_clk and samples the masked requests and levels on the same clock.
*/
`timescale 1ns/1ps
module eipr_regs
  import eipr_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic [7:0] sfr_addr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  output logic [7:0]      sfr_rdata,
  input  wire logic       temp_sensor_req,
  input  wire logic       timer_five_low_overflow,
  input  wire logic       timer_five_high_overflow,
  input  wire logic       timer_four_low_overflow,
  input  wire logic       timer_four_high_overflow,
  input  wire logic       serial_bus_b_req,
  input  wire logic [6:0] prio_src_req,
  output logic            temp_sensor_irq,
  output logic            timer_five_irq,
  output logic            timer_four_irq,
  output logic            serial_bus_b_irq,
  output logic [13:0]     prio_level,
  output logic            win_valid,
  output logic [2:0]      win_index,
  output logic [1:0]      win_level
);
  logic [7:0]  ext_priority_low_one;
  logic [7:0]  ext_priority_high_one;
  logic [7:0]  ext_enable_two;
  logic [7:0]  next_low;
  logic [7:0]  next_high;
  logic [7:0]  next_enable;
  logic [7:0]  next_rdata;
  logic        next_temp;
  logic        next_t5;
  logic        next_t4;
  logic        next_sb;
  logic [13:0] next_levels;

  // ---------------------------------------------------------------
  // Register writes and reads
  // ---------------------------------------------------------------
  always_comb begin
    next_low    = ext_priority_low_one;
    next_high   = ext_priority_high_one;
    next_enable = ext_enable_two;
    next_rdata  = sfr_rdata;
    if (sfr_wr) begin
      unique case (sfr_addr)
        ADDR_PRIO_LOW_ONE:  next_low    = sfr_wdata;
        ADDR_PRIO_HIGH_ONE: next_high   = sfr_wdata;
        ADDR_ENABLE_TWO:    next_enable = sfr_wdata;
        default: ;
      endcase
    end
    if (sfr_rd) begin
      unique case (sfr_addr)
        ADDR_PRIO_LOW_ONE:  next_rdata = ext_priority_low_one;
        ADDR_PRIO_HIGH_ONE: next_rdata = ext_priority_high_one;
        ADDR_ENABLE_TWO:    next_rdata = ext_enable_two;
        default:            next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ext_priority_low_one  <= RESET_VALUE;
      ext_priority_high_one <= RESET_VALUE;
      ext_enable_two        <= RESET_VALUE;
      sfr_rdata             <= 8'h00;
    end else begin
      ext_priority_low_one  <= next_low;
      ext_priority_high_one <= next_high;
      ext_enable_two        <= next_enable;
      sfr_rdata             <= next_rdata;
    end
  end

  // ---------------------------------------------------------------
  // Request masking and priority levels
  // ---------------------------------------------------------------
  always_comb begin
    next_temp = ext_enable_two[BIT_TEMP_EN] & temp_sensor_req;
    next_t5   = ext_enable_two[BIT_TIMER5_EN]
                & (timer_five_low_overflow | timer_five_high_overflow);
    next_t4   = ext_enable_two[BIT_TIMER4_EN]
                & (timer_four_low_overflow | timer_four_high_overflow);
    next_sb   = ext_enable_two[BIT_SERIAL_B_EN] & serial_bus_b_req;
    next_levels[1:0]   = eipr_level(ext_priority_high_one[BIT_SERIAL_A],
                                    ext_priority_low_one[BIT_SERIAL_A]);
    next_levels[3:2]   = eipr_level(ext_priority_high_one[BIT_PORT_MATCH],
                                    ext_priority_low_one[BIT_PORT_MATCH]);
    next_levels[5:4]   = eipr_level(ext_priority_high_one[BIT_CONV_WINDOW],
                                    ext_priority_low_one[BIT_CONV_WINDOW]);
    next_levels[7:6]   = eipr_level(ext_priority_high_one[BIT_CONV_DONE],
                                    ext_priority_low_one[BIT_CONV_DONE]);
    next_levels[9:8]   = eipr_level(ext_priority_high_one[BIT_COUNTER_ARR],
                                    ext_priority_low_one[BIT_COUNTER_ARR]);
    next_levels[11:10] = eipr_level(ext_priority_high_one[BIT_COMPARATOR],
                                    ext_priority_low_one[BIT_COMPARATOR]);
    next_levels[13:12] = eipr_level(ext_priority_high_one[BIT_TIMER_THREE],
                                    ext_priority_low_one[BIT_TIMER_THREE]);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      temp_sensor_irq  <= 1'b0;
      timer_five_irq   <= 1'b0;
      timer_four_irq   <= 1'b0;
      serial_bus_b_irq <= 1'b0;
      prio_level       <= 14'h0000;
    end else begin
      temp_sensor_irq  <= next_temp;
      timer_five_irq   <= next_t5;
      timer_four_irq   <= next_t4;
      serial_bus_b_irq <= next_sb;
      prio_level       <= next_levels;
    end
  end

  // ---------------------------------------------------------------
  // Competing requests
  // ---------------------------------------------------------------
  eipr_arbiter #(
    .N (NUM_SOURCES)
  ) u_arbiter (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .req       (prio_src_req),
    .levels    (prio_level),
    .win_valid (win_valid),
    .win_index (win_index),
    .win_level (win_level)
  );

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_temp_mask: assert property (@(posedge sys_clk) disable iff (rst)
    !ext_enable_two[BIT_TEMP_EN] |=> !temp_sensor_irq)
    else $error("Temperature request passed while masked.");
  a_temp_pass: assert property (@(posedge sys_clk) disable iff (rst)
    (ext_enable_two[BIT_TEMP_EN] && temp_sensor_req) |=> temp_sensor_irq)
    else $error("Temperature request lost while enabled.");
  a_timer5_gate: assert property (@(posedge sys_clk) disable iff (rst)
    (ext_enable_two[BIT_TIMER5_EN] && timer_five_high_overflow) |=> timer_five_irq)
    else $error("Timer five overflow not raised.");
  a_timer5_low: assert property (@(posedge sys_clk) disable iff (rst)
    (ext_enable_two[BIT_TIMER5_EN] && timer_five_low_overflow) |=> timer_five_irq)
    else $error("Timer five low overflow not raised.");
  a_timer5_block: assert property (@(posedge sys_clk) disable iff (rst)
    !ext_enable_two[BIT_TIMER5_EN] |=> !timer_five_irq)
    else $error("Timer five request raised while disabled.");
  a_timer4_gate: assert property (@(posedge sys_clk) disable iff (rst)
    timer_four_irq |-> $past(ext_enable_two[BIT_TIMER4_EN]))
    else $error("Timer four request raised while disabled.");
  a_timer4_raise: assert property (@(posedge sys_clk) disable iff (rst)
    (ext_enable_two[BIT_TIMER4_EN] && (timer_four_low_overflow || timer_four_high_overflow))
    |=> timer_four_irq)
    else $error("Timer four overflow not raised.");
  a_serial_b_mask: assert property (@(posedge sys_clk) disable iff (rst)
    (ext_enable_two[BIT_SERIAL_B_EN] && serial_bus_b_req) |=> serial_bus_b_irq)
    else $error("Second serial bus request lost.");
  a_serial_b_block: assert property (@(posedge sys_clk) disable iff (rst)
    !ext_enable_two[BIT_SERIAL_B_EN] |=> !serial_bus_b_irq)
    else $error("Second serial bus request passed while masked.");
  a_low_write: assert property (@(posedge sys_clk) disable iff (rst)
    (sfr_wr && sfr_addr == ADDR_PRIO_LOW_ONE) |=> ##1
    prio_level[12] == $past(sfr_wdata[BIT_TIMER_THREE], 2))
    else $error("Timer three low priority bit wrong.");
  a_low_upper: assert property (@(posedge sys_clk) disable iff (rst)
    (sfr_wr && sfr_addr == ADDR_PRIO_LOW_ONE) |=> ##1
    {prio_level[10], prio_level[8]}
    == $past({sfr_wdata[BIT_COMPARATOR], sfr_wdata[BIT_COUNTER_ARR]}, 2))
    else $error("Comparator or counter array low priority bit wrong.");
  a_low_serial: assert property (@(posedge sys_clk) disable iff (rst)
    (sfr_wr && sfr_addr == ADDR_PRIO_LOW_ONE) |=> ##1
    prio_level[0] == $past(sfr_wdata[BIT_SERIAL_A], 2))
    else $error("Serial bus low priority bit wrong.");
  a_low_conv: assert property (@(posedge sys_clk) disable iff (rst)
    (sfr_wr && sfr_addr == ADDR_PRIO_LOW_ONE) |=> ##1
    {prio_level[6], prio_level[4], prio_level[2]}
    == $past({sfr_wdata[BIT_CONV_DONE], sfr_wdata[BIT_CONV_WINDOW],
              sfr_wdata[BIT_PORT_MATCH]}, 2))
    else $error("Converter or port match low priority bit wrong.");
  a_high_write: assert property (@(posedge sys_clk) disable iff (rst)
    (sfr_wr && sfr_addr == ADDR_PRIO_HIGH_ONE) |=> ##1
    prio_level[9] == $past(sfr_wdata[BIT_COUNTER_ARR], 2))
    else $error("Counter array high priority bit wrong.");
  a_high_upper: assert property (@(posedge sys_clk) disable iff (rst)
    (sfr_wr && sfr_addr == ADDR_PRIO_HIGH_ONE) |=> ##1
    {prio_level[13], prio_level[11]}
    == $past({sfr_wdata[BIT_TIMER_THREE], sfr_wdata[BIT_COMPARATOR]}, 2))
    else $error("Timer three or comparator high priority bit wrong.");
  a_high_conv: assert property (@(posedge sys_clk) disable iff (rst)
    (sfr_wr && sfr_addr == ADDR_PRIO_HIGH_ONE) |=> ##1
    prio_level[7] == $past(sfr_wdata[BIT_CONV_DONE], 2))
    else $error("Converter high priority bit wrong.");
  a_high_lower: assert property (@(posedge sys_clk) disable iff (rst)
    (sfr_wr && sfr_addr == ADDR_PRIO_HIGH_ONE) |=> ##1
    {prio_level[5], prio_level[3], prio_level[1]}
    == $past({sfr_wdata[BIT_CONV_WINDOW], sfr_wdata[BIT_PORT_MATCH],
              sfr_wdata[BIT_SERIAL_A]}, 2))
    else $error("Window, port match or serial high priority bit wrong.");
  a_win_top: assert property (@(posedge sys_clk) disable iff (rst)
    (prio_src_req[6] && prio_level[13:12] == 2'h3) |=> (win_valid && win_level == 2'h3))
    else $error("Highest level did not win.");

  // ---------------------------------------------------------------
  // Register read-back checks
  // ---------------------------------------------------------------
  a_read_low: assert property (@(posedge sys_clk) disable iff (rst)
    (sfr_rd && sfr_addr == ADDR_PRIO_LOW_ONE) |=> sfr_rdata == $past(ext_priority_low_one))
    else $error("Low priority register read back wrong.");
  a_read_enable: assert property (@(posedge sys_clk) disable iff (rst)
    (sfr_rd && sfr_addr == ADDR_ENABLE_TWO) |=> sfr_rdata == $past(ext_enable_two))
    else $error("Enable register read back wrong.");

endmodule // eipr_regs

/* File: sim/eipr_src_model.sv */
/*
  Peripheral source model: registers the request levels chosen by the bench.
  Assumes the bench hands it a new pattern shortly after a rising edge.
*/
`timescale 1ns/1ps
module eipr_src_model (
  input  wire logic        sys_clk,
  input  wire logic [12:0] pattern,
  output logic [12:0]      req
);
  // Sources hold request levels steady from one clock edge to the next.
  always_ff @(posedge sys_clk) begin
    req <= pattern;
  end
endmodule // eipr_src_model

/* File: sim/test_ext_irq_priority_enable_regs.sv */
/*
  Self-checking bench for the enable and priority register block.
  Assumes the register port and request timing given for eipr_regs.
*/
`timescale 1ns/1ps
module test_ext_irq_priority_enable_regs;
  import eipr_pkg::*;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  sfr_addr = 8'h00;
  logic [7:0]  sfr_wdata = 8'h00;
  logic        sfr_wr = 1'b0;
  logic        sfr_rd = 1'b0;
  logic [7:0]  sfr_rdata;
  logic [12:0] pattern = 13'h0000;
  logic [12:0] req;
  logic [3:0]  irqs;
  logic [13:0] prio_level;
  logic        win_valid;
  logic [2:0]  win_index;
  logic [1:0]  win_level;
  logic [31:0] lfsr = 32'hfbc1_412f;
  int          num_errors = 0;
  int          samples_checked = 0;

  always #2.5 sys_clk = ~sys_clk;

  eipr_src_model eipr_src_model_inst (.sys_clk(sys_clk), .pattern(pattern), .req(req));
  eipr_regs eipr_regs_inst (
    .sys_clk(sys_clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .temp_sensor_req(req[7]), .timer_five_low_overflow(req[8]),
    .timer_five_high_overflow(req[9]), .timer_four_low_overflow(req[10]),
    .timer_four_high_overflow(req[11]), .serial_bus_b_req(req[12]),
    .prio_src_req(req[6:0]), .temp_sensor_irq(irqs[3]), .timer_five_irq(irqs[2]),
    .timer_four_irq(irqs[1]), .serial_bus_b_irq(irqs[0]), .prio_level(prio_level),
    .win_valid(win_valid), .win_index(win_index), .win_level(win_level));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] l);
    return {l[30:0], l[31] ^ l[21] ^ l[1] ^ l[0]};
  endfunction

  function automatic logic [13:0] exp_levels(input logic [7:0] hi, input logic [7:0] lo);
    logic [13:0] e;
    for (int i = 0; i < 7; i++) begin
      e[2*i+1] = hi[(i == 6) ? 7 : i];
      e[2*i]   = lo[(i == 6) ? 7 : i];
    end
    return e;
  endfunction

  function automatic logic [5:0] exp_win(input logic [6:0] r, input logic [13:0] lv);
    logic [5:0] w;
    w = 6'h00;
    for (int i = 0; i < 7; i++) begin
      if (r[i] && (!w[5] || lv[2*i+:2] > w[1:0])) w = {1'b1, 3'(i), lv[2*i+:2]};
    end
    return w;
  endfunction

  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask

  task automatic summarize();
    if (num_errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t register got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_out(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t output got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    tick();
    sfr_wr = 1'b0;
    tick();
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    sfr_addr = a;
    sfr_rd = 1'b1;
    tick();
    sfr_rd = 1'b0;
    tick();
    d = sfr_rdata;
  endtask

  // Reads every register back after reset and checks that the priority levels and masked requests are idle.
  task automatic check_cleared();
    logic [7:0] d;
    logic [7:0] addrs [4];
    addrs = '{ADDR_PRIO_HIGH_ONE, ADDR_ENABLE_TWO, ADDR_PRIO_LOW_ONE, 8'h10};
    foreach (addrs[i]) begin
      rd(addrs[i], d);
      cmp_reg(d, RESET_VALUE);
    end
    cmp_out({2'b00, prio_level}, 16'h0000);
    cmp_out({12'h000, irqs}, 16'h0000);
  endtask

  // Writes all three registers, reads them back, then checks every output.
  task automatic run(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] en,
                     input logic [12:0] pat);
    logic [7:0]  d;
    logic [13:0] lv;
    logic [5:0]  w;
    logic [5:0]  g;
    pattern = pat;
    wr(ADDR_PRIO_HIGH_ONE, hi);
    wr(ADDR_PRIO_LOW_ONE, lo);
    wr(ADDR_ENABLE_TWO, en);
    rd(ADDR_PRIO_HIGH_ONE, d);
    cmp_reg(d, hi);
    rd(ADDR_PRIO_LOW_ONE, d);
    cmp_reg(d, lo);
    rd(ADDR_ENABLE_TWO, d);
    cmp_reg(d, en);
    lv = exp_levels(hi, lo);
    cmp_out({2'b00, prio_level}, {2'b00, lv});
    cmp_out({12'h000, irqs}, {12'h000, pat[7] & en[3], (pat[8] | pat[9]) & en[2],
            (pat[10] | pat[11]) & en[1], pat[12] & en[0]});
    w = exp_win(pat[6:0], lv);
    g = {win_valid, win_index, win_level};
    cmp_out({10'h000, w[5] ? g : {g[5], 5'h00}}, {10'h000, w});
  endtask

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    logic [7:0] d;
    repeat (12) tick();
    rst = 1'b0;
    tick();
    check_cleared();
    wr(8'h10, 8'h5a);
    rd(8'h10, d);
    cmp_reg(d, 8'h00);
    run(8'hbf, 8'hbf, 8'h0f, 13'h1fff);
    run(8'h00, 8'h00, 8'h00, 13'h1fff);
    run(8'h80, 8'h01, 8'h06, 13'h0d41);
    run(8'h04, 8'h3f, 8'h09, 13'h068e);
    for (int n = 0; n < 40; n++) begin
      lfsr = lfsr_next(lfsr);
      run(lfsr[7:0] & 8'hbf, lfsr[15:8] & 8'hbf, lfsr[23:16] & 8'h0f, lfsr[31:19]);
    end
    rst = 1'b1;
    repeat (2) tick();
    rst = 1'b0;
    tick();
    check_cleared();
    run(8'h21, 8'h12, 8'h0c, 13'h0f3c);
    summarize();
  end

  initial begin
    repeat (5000) @(posedge sys_clk);
    num_errors++;
    summarize();
  end
endmodule // test_ext_irq_priority_enable_regs
